//--- ocq_ctrl_model.sv
// system controller model: watches the fault net, drives mode and enable
// assumes a pull-up on the fault net and the qualifier's clk_sys
module ocq_ctrl_model (
  input wire logic clk_sys,
  input wire logic alert_n_out,
  input wire logic alert_n_oe,
  output logic alert_pin,
  output logic held_mode,
  output logic enable
);
  timeunit 1ns;
  timeprecision 1ns;
  // =====================================
  // fault net
  // a released net reads high through the pull-up
  assign alert_pin = alert_n_oe ? alert_n_out : 1'b1;
  initial begin
    held_mode = 1'b0;
    enable = 1'b1;
  end
  // =====================================
  // controller actions
  task automatic set_mode(input logic v);
    @(posedge clk_sys);
    held_mode <= v;
  endtask : set_mode
  task automatic set_enable(input logic v);
    @(posedge clk_sys);
    enable <= v;
  endtask : set_enable
  // low well past 20 us so that a window end falls inside
  task automatic clear_latch();
    set_mode(1'b0);
    repeat (310) @(posedge clk_sys);
    held_mode <= 1'b1;
  endtask : clear_latch
endmodule : ocq_ctrl_model

//--- ocq_map.svh
// constants of the overcurrent alert qualifier: timing, counts and strap codes
// assumes a 100 ns system clock; included by the package and the design
`ifndef OCQ_MAP_SVH
`define OCQ_MAP_SVH

// =====================================
// timing
`define OCQ_CLK_PERIOD_NS 100
`define OCQ_WINDOW_NS 10000
`define OCQ_CLEAR_LOW_NS 20000
`define OCQ_WINDOW_CYC ((`OCQ_WINDOW_NS) / (`OCQ_CLK_PERIOD_NS))
`define OCQ_CLEAR_LOW_CYC (((`OCQ_CLEAR_LOW_NS) + (`OCQ_CLK_PERIOD_NS) - 1) / (`OCQ_CLK_PERIOD_NS))

// =====================================
// consecutive over-limit windows per response setting
`define OCQ_WINS_10US 4'h1
`define OCQ_WINS_50US 4'h5
`define OCQ_WINS_100US 4'ha

// =====================================
// three-level strap codes as delivered by the level detector
`define OCQ_STRAP_FLOAT 2'h0
`define OCQ_STRAP_GND 2'h1
`define OCQ_STRAP_SUPPLY 2'h2

// band select codes towards the analog comparator
`define OCQ_BAND_2MV 2'h0
`define OCQ_BAND_4MV 2'h1
`define OCQ_BAND_8MV 2'h2

`endif

//--- ocq_pkg.sv
// types of the overcurrent alert qualifier
// assumes ocq_map.svh is on the include path
`include "ocq_map.svh"

package ocq_pkg;

  // =====================================
  // decoded strap level
  typedef enum logic [1:0] {
    OCQ_LVL_FLOAT = 2'h0,
    OCQ_LVL_GND = 2'h1,
    OCQ_LVL_SUPPLY = 2'h2
  } ocq_level_t;

  // =====================================
  // output state
  typedef enum logic [0:0] {
    OCQ_RELEASED = 1'h0,
    OCQ_ASSERTED = 1'h1
  } ocq_state_t;

endpackage : ocq_pkg

//--- ocq_qualifier.sv
// digital qualification of an overcurrent comparator with open-drain fault output
// assumes comparator, strap level detectors and the controller pins are asynchronous to clk_sys
`include "ocq_map.svh"

// Overview of operation
// - response strap: float 10 us, ground 50 us, supply 100 us
// - 10 us window runs freely while enabled, disable holds it at zero; no other external control or indication
// - each window end gives one over-limit verdict from averaged input
// - latency varies by up to one window, crossing is unsynchronised
// - 10 us setting asserts fault at end of first over-limit window
// - 50 us setting needs five consecutive over-limit windows
// - latency grows by 40 us and 90 us for longer settings
// - hysteresis strap: float 2 mV, ground 4 mV, supply 8 mV
// - fault output active low open drain, released otherwise
// - mode low selects transparent output following qualified state
// - transparent mode releases after input below trip for 10 us
// - 100 us setting needs ten consecutive over-limit windows
// - any under-limit window resets the consecutive counter
// - held mode keeps fault; cleared by mode low 20 us if input below
// - disable resets the consecutive counter, restarts on re-enable
module ocq_qualifier (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic enable,
  input wire logic held_mode,
  input wire logic sense_over,
  input wire logic [1:0] response_strap,
  input wire logic [1:0] band_strap,
  output logic [1:0] band_width_select,
  output logic alert_n_out,
  output logic alert_n_oe,
  output ocq_pkg::ocq_level_t response_level
);
  import ocq_pkg::*;

  localparam logic [6:0] WIN_LAST = 7'(`OCQ_WINDOW_CYC - 1);
  localparam logic [6:0] WIN_HALF = 7'(`OCQ_WINDOW_CYC / 2);
  localparam logic [7:0] CLR_CYC = 8'(`OCQ_CLEAR_LOW_CYC);

  // =====================================
  // pin synchronisers
  logic [5:0] sync1_ff;
  logic [5:0] sync2_ff;
  // no reset here: the straps must already be through both stages when reset lifts
  always_ff @(posedge clk_sys) begin
    sync1_ff <= {band_strap, response_strap, held_mode, enable};
    sync2_ff <= sync1_ff;
  end
  logic en_s;
  logic held_s;
  assign en_s = sync2_ff[0];
  assign held_s = sync2_ff[1];

  // =====================================
  // straps caught once after reset release
  logic strap_done_ff;
  logic [1:0] resp_strap_ff;
  logic [1:0] band_strap_ff;
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      strap_done_ff <= 1'b0;
      resp_strap_ff <= `OCQ_STRAP_FLOAT;
      band_strap_ff <= `OCQ_STRAP_FLOAT;
    end else if (!strap_done_ff) begin
      strap_done_ff <= 1'b1;
      resp_strap_ff <= sync2_ff[3:2];
      band_strap_ff <= sync2_ff[5:4];
    end
  end

  logic [3:0] wins_needed;
  always_comb begin
    if (resp_strap_ff == `OCQ_STRAP_GND) begin
      wins_needed = `OCQ_WINS_50US;
      response_level = OCQ_LVL_GND;
    end else if (resp_strap_ff == `OCQ_STRAP_SUPPLY) begin
      wins_needed = `OCQ_WINS_100US;
      response_level = OCQ_LVL_SUPPLY;
    end else begin
      wins_needed = `OCQ_WINS_10US;
      response_level = OCQ_LVL_FLOAT;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      band_width_select <= `OCQ_BAND_2MV;
    end else if (band_strap_ff == `OCQ_STRAP_GND) begin
      band_width_select <= `OCQ_BAND_4MV;
    end else if (band_strap_ff == `OCQ_STRAP_SUPPLY) begin
      band_width_select <= `OCQ_BAND_8MV;
    end else begin
      band_width_select <= `OCQ_BAND_2MV;
    end
  end

  // =====================================
  // free-running comparison window
  // not aligned to the input, so latency spreads over one window
  logic [6:0] win_cnt_ff;
  logic win_end;
  assign win_end = en_s && (win_cnt_ff == WIN_LAST);
  always_ff @(posedge clk_sys) begin
    if (!rstn || !en_s) begin
      win_cnt_ff <= 7'h0;
    end else if (win_cnt_ff == WIN_LAST) begin
      win_cnt_ff <= 7'h0;
    end else begin
      win_cnt_ff <= win_cnt_ff + 7'h1;
    end
  end

  // averaging: count over samples, majority of the window means over
  logic sense1_ff;
  logic sense2_ff;
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      sense1_ff <= 1'b0;
      sense2_ff <= 1'b0;
    end else begin
      sense1_ff <= sense_over;
      sense2_ff <= sense1_ff;
    end
  end

  logic [6:0] over_cnt_ff;
  logic [6:0] over_total;
  logic win_over;
  assign over_total = over_cnt_ff + {6'h0, sense2_ff};
  assign win_over = over_total > WIN_HALF;

  always_ff @(posedge clk_sys) begin
    if (!rstn || !en_s || win_end) begin
      over_cnt_ff <= 7'h0;
    end else if (sense2_ff) begin
      over_cnt_ff <= over_cnt_ff + 7'h1;
    end
  end

  // =====================================
  // consecutive over-limit windows
  logic [3:0] cons_ff;
  logic qualified;
  assign qualified = win_end && win_over && ((cons_ff + 4'h1) >= wins_needed);
  always_ff @(posedge clk_sys) begin
    if (!rstn || !en_s) begin
      cons_ff <= 4'h0;
    end else if (win_end && !win_over) begin
      cons_ff <= 4'h0;
    end else if (win_end && cons_ff < wins_needed) begin
      cons_ff <= cons_ff + 4'h1;
    end
  end

  // =====================================
  // mode low time for clearing a held fault
  logic [7:0] low_cnt_ff;
  logic clear_ok;
  assign clear_ok = (low_cnt_ff >= CLR_CYC);
  always_ff @(posedge clk_sys) begin
    if (!rstn || held_s) begin
      low_cnt_ff <= 8'h0;
    end else if (!clear_ok) begin
      low_cnt_ff <= low_cnt_ff + 8'h1;
    end
  end

  // =====================================
  // fault state and open-drain output
  ocq_state_t state_ff;
  always_ff @(posedge clk_sys) begin
    if (!rstn || !en_s) begin
      state_ff <= OCQ_RELEASED;
    end else begin
      case (state_ff)
        OCQ_RELEASED: begin
          if (qualified) begin
            state_ff <= OCQ_ASSERTED;
          end
        end
        OCQ_ASSERTED: begin
          // held mode never releases; low mode needs 20 us low before it follows
          if (win_end && !win_over && !held_s && clear_ok) begin
            state_ff <= OCQ_RELEASED;
          end
        end
        default: begin
          state_ff <= OCQ_RELEASED;
        end
      endcase
    end
  end

  assign alert_n_out = 1'b0;
  assign alert_n_oe = (state_ff == OCQ_ASSERTED);

  // =====================================
  // checks
  sequence s_win_restart;
    (win_cnt_ff == 7'h0) ##99 win_end;
  endsequence

  property p_win_period;
    @(posedge clk_sys) disable iff (!rstn || !en_s)
      win_end |=> s_win_restart;
  endproperty
  a_win_period: assert property (p_win_period) else $error("window period not 100 cycles");

  property p_assert_only_at_win_end;
    @(posedge clk_sys) disable iff (!rstn)
      $rose(alert_n_oe) |-> $past(win_end) && $past(win_over);
  endproperty
  a_assert_only_at_win_end: assert property (p_assert_only_at_win_end) else $error("fault set off window end");

  property p_count_met;
    @(posedge clk_sys) disable iff (!rstn)
      $rose(alert_n_oe) |-> ($past(cons_ff) + 4'h1) >= $past(wins_needed);
  endproperty
  a_count_met: assert property (p_count_met) else $error("fault set before enough windows");

  property p_under_resets;
    @(posedge clk_sys) disable iff (!rstn || !en_s)
      (win_end && !win_over) |=> cons_ff == 4'h0;
  endproperty
  a_under_resets: assert property (p_under_resets) else $error("counter kept after under window");

  property p_disable_clears;
    @(posedge clk_sys) disable iff (!rstn)
      !en_s |=> (cons_ff == 4'h0) && !alert_n_oe && (win_cnt_ff == 7'h0);
  endproperty
  a_disable_clears: assert property (p_disable_clears) else $error("disable did not clear");

  property p_held_keeps;
    @(posedge clk_sys) disable iff (!rstn || !en_s)
      (alert_n_oe && held_s) |=> alert_n_oe;
  endproperty
  a_held_keeps: assert property (p_held_keeps) else $error("held fault released");

  property p_transparent_release;
    @(posedge clk_sys) disable iff (!rstn || !en_s)
      (alert_n_oe && win_end && !win_over && !held_s && clear_ok) |=> !alert_n_oe;
  endproperty
  a_transparent_release: assert property (p_transparent_release) else $error("fault not released");

  property p_release_needs_under;
    @(posedge clk_sys) disable iff (!rstn || !en_s)
      $fell(alert_n_oe) |-> $past(win_end) && !$past(win_over) && $past(clear_ok);
  endproperty
  a_release_needs_under: assert property (p_release_needs_under) else $error("release without under window");

  property p_fast_setting;
    @(posedge clk_sys) disable iff (!rstn || !en_s)
      (wins_needed == `OCQ_WINS_10US && win_end && win_over) |=> alert_n_oe;
  endproperty
  a_fast_setting: assert property (p_fast_setting) else $error("fast setting missed first window");

  // a reset cycle must leave the drain released and never drive the pin high
  property p_open_drain;
    @(posedge clk_sys)
      !rstn |=> !alert_n_oe && (alert_n_out == 1'b0);
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("drain not released after reset");

endmodule : ocq_qualifier

//--- ocq_qualifier_test.sv
// self-checking bench of the overcurrent alert qualifier
// assumes ocq_map.svh on the include path and ocq_ctrl_model compiled first
`include "ocq_map.svh"
module ocq_qualifier_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int W = `OCQ_WINDOW_CYC;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic sense_over = 1'b0;
  logic [1:0] response_strap = 2'h0;
  logic [1:0] band_strap = 2'h0;
  logic [1:0] band_width_select;
  logic alert_n_out, alert_n_oe, alert_pin, held_mode, enable;
  ocq_pkg::ocq_level_t response_level;
  int n_mismatch = 0;
  int samples_checked = 0;
  integer seed = 32'h7f69;
  int cyc = 0;
  int f;
  initial begin
    forever #50 clk_sys = ~clk_sys;
  end
  ocq_qualifier i_dut (.clk_sys(clk_sys), .rstn(rstn), .enable(enable), .held_mode(held_mode),
    .sense_over(sense_over), .response_strap(response_strap), .band_strap(band_strap),
    .band_width_select(band_width_select), .alert_n_out(alert_n_out), .alert_n_oe(alert_n_oe),
    .response_level(response_level));
  ocq_ctrl_model i_ctrl (.clk_sys(clk_sys), .alert_n_out(alert_n_out), .alert_n_oe(alert_n_oe),
    .alert_pin(alert_pin), .held_mode(held_mode), .enable(enable));
  // =====================================
  // expectations
  function automatic int need(input logic [1:0] s);
    return s == `OCQ_STRAP_GND ? `OCQ_WINS_50US : s == `OCQ_STRAP_SUPPLY ? `OCQ_WINS_100US : `OCQ_WINS_10US;
  endfunction : need
  function automatic logic [1:0] band_exp(input logic [1:0] b);
    return b == `OCQ_STRAP_GND ? `OCQ_BAND_4MV : b == `OCQ_STRAP_SUPPLY ? `OCQ_BAND_8MV : `OCQ_BAND_2MV;
  endfunction : band_exp
  // =====================================
  // helpers
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  // first = cycle at which the pin first shows want, -1 if never
  task automatic drive(input logic v, input int n, input logic want, output int first);
    first = -1;
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys);
      sense_over <= v;
      if (first < 0 && alert_pin === want) first = i;
    end
  endtask : drive
  task automatic restart(input logic [1:0] s, input logic [1:0] b);
    @(posedge clk_sys);
    rstn <= 1'b0;
    response_strap <= s;
    band_strap <= b;
    sense_over <= 1'b0;
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk("band", band_exp(b), band_width_select);
    chk("level", s == 2'h3 ? 2'h0 : s, response_level);
    chk("pin", 1, alert_pin);
  endtask : restart
  // =====================================
  // main sequence
  initial begin
    int lo;
    int len;
    int hi;
    for (int s = 0; s < 4; s++) begin
      restart(2'(s), 2'($unsigned($random(seed)) % 3));
      lo = need(2'(s)) * W;
      // longest burst that can never fill the count, whatever the window phase
      hi = lo > W ? lo - W + 1 : W / 2;
      len = 1 + $unsigned($random(seed)) % hi;
      for (int k = 0; k < 2; k++) begin
        drive(1'b1, k ? len : hi, 1'b0, f);
        chk("short", -1, f);
        drive(1'b0, 2 * W, 1'b0, f);
        chk("tail", -1, f);
      end
      drive(1'b1, lo + W + 10, 1'b0, f);
      chk("rise", 1, f >= lo - W + 51 && f <= lo + W + 5);
      drive(1'b0, 2 * W + 10, 1'b1, f);
      chk("fall", 1, f >= 50 && f <= 2 * W + 5);
      $display("strap %0d done", s);
    end
    restart(2'h1, 2'h0);
    drive(1'b1, 3 * W, 1'b0, f);
    drive(1'b0, W, 1'b0, f);
    drive(1'b1, 3 * W, 1'b0, f);
    chk("gap", -1, f);
    drive(1'b0, W, 1'b0, f);
    drive(1'b1, 4 * W, 1'b0, f);
    chk("pre_off", -1, f);
    i_ctrl.set_enable(1'b0);
    repeat (10) @(posedge clk_sys);
    i_ctrl.set_enable(1'b1);
    // a counter kept over the disable would fire after the first window
    drive(1'b1, 6 * W, 1'b0, f);
    chk("reenable", 1, f >= 9 * W / 2 && f <= 11 * W / 2);
    $display("counter reset done");
    restart(2'h0, 2'h2);
    i_ctrl.set_mode(1'b1);
    drive(1'b1, 2 * W + 10, 1'b0, f);
    chk("od", 0, alert_n_out);
    drive(1'b0, 3 * W, 1'b1, f);
    chk("held", -1, f);
    i_ctrl.set_enable(1'b0);
    repeat (5) @(posedge clk_sys);
    chk("off", 1, alert_pin);
    i_ctrl.set_enable(1'b1);
    drive(1'b1, 2 * W + 10, 1'b0, f);
    fork
      drive(1'b1, 4 * W, 1'b1, f);
      i_ctrl.clear_latch();
    join
    chk("clear_over", -1, f);
    drive(1'b0, 3 * W, 1'b1, f);
    chk("held2", -1, f);
    // mode low for well under 20 us must not clear, though windows are under
    i_ctrl.set_mode(1'b0);
    drive(1'b0, 3 * W / 2, 1'b1, f);
    i_ctrl.set_mode(1'b1);
    chk("short_clear", -1, f);
    fork
      drive(1'b0, 4 * W, 1'b1, f);
      i_ctrl.clear_latch();
    join
    chk("clear", 1, f >= 0);
    $display("held mode done");
    report_and_stop();
  end
endmodule : ocq_qualifier_test
